// ---- emrx_chk.sv ----
// concurrent checks on the ports of the rx error tally and configuration block
// assumes one clock mclk and a synchronous active high reset
`timescale 1ns/1ps
`include "emrx_consts.vh"
module emrx_chk (
   input logic mclk,
   input logic reset,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_we_i,
   input logic [`EMRX_ADR_W-1:0] wb_adr_i,
   input logic [31:0] wb_dat_o,
   input logic wb_ack_o,
   input logic rx_frame_end,
   input logic rx_fcs_fail,
   input logic rx_pause_frame,
   input logic frame_accept,
   input logic pause_apply,
   input logic tx_pause_req,
   input logic tx_pause_go,
   input logic tx_en,
   input logic mii_tx_en,
   input logic mac_and_media_logic_hold,
   input logic rx_control_sublayer_hold,
   input logic rx_function_hold,
   input logic tx_control_sublayer_hold,
   input logic tx_function_hold
);
   // ****************************************************
   // properties
   // ****************************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   chk_ack_pulse: assert property (s_take |=> s_pulse)
      else $error("ack not a single pulse after request");
   chk_tally_upper: assert property (wb_ack_o && !wb_we_i &&
      (wb_adr_i == 8'h10 || wb_adr_i == 8'h20) |-> wb_dat_o[31:16] == 16'h0000)
      else $error("tally upper half not zero");
   chk_cfg_unused: assert property (wb_ack_o && !wb_we_i &&
      wb_adr_i == 8'h00 |-> (wb_dat_o & 32'hFFFF30E0) == 32'h00000000)
      else $error("unused config bits read nonzero");
   chk_pause_gate: assert property (tx_pause_go |-> $past(tx_pause_req) &&
      !tx_control_sublayer_hold && !mac_and_media_logic_hold)
      else $error("pause sent without cause");
   chk_pause_cause: assert property (pause_apply |->
      $past(rx_frame_end && rx_pause_frame && !rx_fcs_fail) && !rx_control_sublayer_hold)
      else $error("pause applied without cause");
   chk_accept_cause: assert property (frame_accept |->
      $past(rx_frame_end && !rx_fcs_fail) && !rx_function_hold)
      else $error("frame accepted without cause");
   chk_whole_hold: assert property (mac_and_media_logic_hold |->
      rx_control_sublayer_hold && rx_function_hold && tx_control_sublayer_hold
      && tx_function_hold)
      else $error("whole hold did not hold parts");
   chk_tx_gate: assert property (mii_tx_en |-> $past(tx_en) && !tx_function_hold)
      else $error("transmit enable while held");
   chk_hold_reset: assert property ($fell(reset) |-> mac_and_media_logic_hold)
      else $error("whole hold low after reset");
endmodule
bind emrx_top emrx_chk u_chk (.mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .rx_frame_end(rx_frame_end), .rx_fcs_fail(rx_fcs_fail),
   .rx_pause_frame(rx_pause_frame), .frame_accept(frame_accept),
   .pause_apply(pause_apply), .tx_pause_req(tx_pause_req), .tx_pause_go(tx_pause_go),
   .tx_en(tx_en), .mii_tx_en(mii_tx_en),
   .mac_and_media_logic_hold(mac_and_media_logic_hold),
   .rx_control_sublayer_hold(rx_control_sublayer_hold),
   .rx_function_hold(rx_function_hold),
   .tx_control_sublayer_hold(tx_control_sublayer_hold),
   .tx_function_hold(tx_function_hold));

// ---- emrx_consts.vh ----
// constants for the mac receive error statistics and configuration one block
// assumes a wishbone byte address of eight bits, word aligned registers
`ifndef EMRX_CONSTS_VH
`define EMRX_CONSTS_VH

// ****************************************************
// register byte offsets
// ****************************************************
`define EMRX_ADR_W 8
`define EMRX_OFS_CFG1 8'h00
`define EMRX_OFS_FCS 8'h10
`define EMRX_OFS_FCS_SET 8'h14
`define EMRX_OFS_FCS_CLR 8'h18
`define EMRX_OFS_FCS_INV 8'h1C
`define EMRX_OFS_ALGN 8'h20
`define EMRX_OFS_ALGN_SET 8'h24
`define EMRX_OFS_ALGN_CLR 8'h28
`define EMRX_OFS_ALGN_INV 8'h2C
`define EMRX_OFS_INT_STAT 8'h30
`define EMRX_OFS_INT_CLR 8'h34
`define EMRX_OFS_INT_EN 8'h38

// ****************************************************
// configuration one fields
// ****************************************************
`define EMRX_CFG_W 16
`define EMRX_CFG_RESET 16'h800D
`define EMRX_CFG_MASK 16'hCF1F
`define EMRX_BIT_WHOLE 15
`define EMRX_BIT_BACKOFF 14
`define EMRX_BIT_RXCS 11
`define EMRX_BIT_RXFN 10
`define EMRX_BIT_TXCS 9
`define EMRX_BIT_TXFN 8
`define EMRX_BIT_LOOP 4
`define EMRX_BIT_TXFLOW 3
`define EMRX_BIT_RXFLOW 2
`define EMRX_BIT_PASS 1
`define EMRX_BIT_RXEN 0

// ****************************************************
// counters and interrupt bits
// ****************************************************
`define EMRX_CNT_W 16
`define EMRX_CNT_RESET 16'h0000
`define EMRX_INT_W 2
`define EMRX_INT_FCS 0
`define EMRX_INT_ALGN 1
`define EMRX_MII_W 4

`endif

// ---- emrx_err_counter.v ----
// one receive error tally with read clear and software load
// assumes the caller has already merged byte lanes and alias modes into load_data
`timescale 1ns/1ps
`include "emrx_consts.vh"
module emrx_err_counter #(
   parameter W = `EMRX_CNT_W
) (
   mclk,
   reset,
   inc,
   rd_clear,
   load,
   load_data,
   count
);
   input wire mclk;
   input wire reset;
   input wire inc;
   input wire rd_clear;
   input wire load;
   input wire [W-1:0] load_data;
   output wire [W-1:0] count;

   reg [W-1:0] count_reg;
   reg [W-1:0] base;
   reg [W-1:0] count_next;

   // ****************************************************
   // tally
   // ****************************************************
   // an event in the clearing cycle is kept, so the tally never loses one
   always @*
   begin
      base = count_reg;
      if (rd_clear)
         base = {W{1'b0}};
      else if (load)
         base = load_data;
      count_next = base + {{(W-1){1'b0}}, inc}; // see (R18)
   end

   always @(posedge mclk)
   begin
      if (reset)
         count_reg <= `EMRX_CNT_RESET;
      else
         count_reg <= count_next;
   end

   assign count = count_reg;
endmodule

// ---- emrx_phy_model.sv ----
// behavioural phy receive side: sends a nibble while go is high
// assumes the bench raises go only for a frame
`timescale 1ns/1ps
module emrx_phy_model (
   input wire logic mclk,
   input wire logic go,
   input wire logic [3:0] nib,
   output logic [3:0] rxd = 4'h0,
   output logic rx_dv = 1'h0
);
   // ****************************************************
   // receive pins
   // ****************************************************
   // idle data toggles so a stale nibble never passes for fresh data
   always @(posedge mclk)
   begin
      rx_dv <= go;
      rxd <= go ? nib : ~rxd;
   end
endmodule

// ---- emrx_sync2.v ----
// two flip-flop synchroniser for pins from the phy
// assumes the pins are levels, slow against mclk for each bit
`timescale 1ns/1ps
module emrx_sync2 #(
   parameter W = 1
) (
   mclk,
   reset,
   async_in,
   sync_out
);
   input wire mclk;
   input wire reset;
   input wire [W-1:0] async_in;
   output wire [W-1:0] sync_out;

   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;

   // ****************************************************
   // synchroniser
   // ****************************************************
   // first stage is read only by the second
   always @(posedge mclk)
   begin
      if (reset)
      begin
         meta_reg <= {W{1'b0}};
         sync_reg <= {W{1'b0}};
      end
      else
      begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;
endmodule

// ---- emrx_top.v ----
// mac receive error statistics, configuration one register and their interrupt
// assumes rx frame status pulses come from logic on mclk, phy pins are asynchronous
//
// Functional notes
// (R1) good-length frames with bad check sequence add one to the fcs tally
// (R2) bad check sequence frames with odd bit length add one to alignment tally
// (R3) tallies are sixteen bits in the low half, upper half reads zero
// (R4) reading a tally clears it unless byte lanes zero and one are off
// (R5) software changes tallies only via set, clear, invert aliases, debug only; a direct write to a tally also loads it
// (R6) whole mac hold bit keeps mac and media logic reset, resets to one
// (R7) backoff random hold bit resets the transmit random generator
// (R8) rx control sublayer hold bit keeps receive control logic in reset
// (R9) rx function hold bit keeps receive function logic in reset
// (R10) tx control sublayer hold bit keeps transmit control logic in reset
// (R11) tx function hold bit keeps transmit function logic in reset
// (R12) loopback bit routes transmit interface into receive interface
// (R13) tx flow bit lets pause frames go out, blocks when zero, resets one
// (R14) rx flow bit acts on received pause frames, ignores when zero, resets one
// (R15) pass bit accepts control frames, ignores them when zero, resets zero
// (R16) frames are received only while receive enable is one, resets one
// (R17) only bits 15, 14, 11 to 8 and 4 to 0 exist, rest read zero
// (R18) a tally at its maximum wraps to zero on the next event
`timescale 1ns/1ps
`include "emrx_consts.vh"
module emrx_top #(
   parameter CNT_W = `EMRX_CNT_W,
   parameter MII_W = `EMRX_MII_W
) (
   mclk,
   reset,
   wb_cyc_i,
   wb_stb_i,
   wb_we_i,
   wb_adr_i,
   wb_sel_i,
   wb_dat_i,
   wb_dat_o,
   wb_ack_o,
   irq,
   rx_frame_end,
   rx_fcs_fail,
   rx_odd_bits,
   rx_control_frame,
   rx_pause_frame,
   tx_pause_req,
   tx_data,
   tx_en,
   phy_rxd,
   phy_rx_dv,
   mii_txd,
   mii_tx_en,
   mac_rx_data,
   mac_rx_dv,
   frame_accept,
   pause_apply,
   tx_pause_go,
   mac_and_media_logic_hold,
   backoff_random_hold,
   rx_control_sublayer_hold,
   rx_function_hold,
   tx_control_sublayer_hold,
   tx_function_hold
);
   input wire mclk;
   input wire reset;
   input wire wb_cyc_i;
   input wire wb_stb_i;
   input wire wb_we_i;
   input wire [`EMRX_ADR_W-1:0] wb_adr_i;
   input wire [3:0] wb_sel_i;
   input wire [31:0] wb_dat_i;
   output wire [31:0] wb_dat_o;
   output wire wb_ack_o;
   output wire irq;
   input wire rx_frame_end;
   input wire rx_fcs_fail;
   input wire rx_odd_bits;
   input wire rx_control_frame;
   input wire rx_pause_frame;
   input wire tx_pause_req;
   input wire [MII_W-1:0] tx_data;
   input wire tx_en;
   input wire [MII_W-1:0] phy_rxd;
   input wire phy_rx_dv;
   output wire [MII_W-1:0] mii_txd;
   output wire mii_tx_en;
   output wire [MII_W-1:0] mac_rx_data;
   output wire mac_rx_dv;
   output wire frame_accept;
   output wire pause_apply;
   output wire tx_pause_go;
   output wire mac_and_media_logic_hold;
   output wire backoff_random_hold;
   output wire rx_control_sublayer_hold;
   output wire rx_function_hold;
   output wire tx_control_sublayer_hold;
   output wire tx_function_hold;

   // ****************************************************
   // declarations
   // ****************************************************
   reg [`EMRX_CFG_W-1:0] cfg_reg;
   reg [`EMRX_CFG_W-1:0] cfg_next;
   reg [`EMRX_INT_W-1:0] int_stat_reg;
   reg [`EMRX_INT_W-1:0] int_stat_next;
   reg [`EMRX_INT_W-1:0] int_en_reg;
   reg [`EMRX_INT_W-1:0] int_en_next;
   reg irq_reg;
   reg ack_reg;
   reg [31:0] dat_reg;
   reg [31:0] dat_next;
   reg [MII_W-1:0] mii_txd_reg;
   reg mii_tx_en_reg;
   reg [MII_W-1:0] mac_rx_data_reg;
   reg mac_rx_dv_reg;
   reg frame_accept_reg;
   reg pause_apply_reg;
   reg tx_pause_go_reg;
   reg [5:0] hold_reg;
   reg fcs_load;
   reg algn_load;
   reg fcs_rd_clear;
   reg algn_rd_clear;
   reg [CNT_W-1:0] fcs_load_data;
   reg [CNT_W-1:0] algn_load_data;
   reg [`EMRX_INT_W-1:0] int_clr;
   wire [CNT_W-1:0] fcs_count;
   wire [CNT_W-1:0] algn_count;
   wire [MII_W-1:0] phy_rxd_s;
   wire phy_rx_dv_s;
   wire req;
   wire wr;
   wire rd;
   wire low_lanes;
   wire [CNT_W-1:0] wdat;
   wire whole_hold;
   wire rx_live;
   wire fcs_inc;
   wire algn_inc;
   wire [`EMRX_INT_W-1:0] int_events;

   // ****************************************************
   // byte lane merge
   // ****************************************************
   function [15:0] lane_merge;
      input [15:0] old_val;
      input [15:0] new_val;
      input [1:0] sel;
      begin
         lane_merge[7:0] = sel[0] ? new_val[7:0] : old_val[7:0];
         lane_merge[15:8] = sel[1] ? new_val[15:8] : old_val[15:8];
      end
   endfunction

   // ****************************************************
   // phy pin synchroniser
   // ****************************************************
   emrx_sync2 #(
      .W(MII_W + 1)
   ) u_rx_sync (
      .mclk(mclk),
      .reset(reset),
      .async_in({phy_rx_dv, phy_rxd}),
      .sync_out({phy_rx_dv_s, phy_rxd_s})
   );

   // ****************************************************
   // frame events
   // ****************************************************
   assign whole_hold = cfg_reg[`EMRX_BIT_WHOLE];
   // a held or disabled receiver sees no frames at all
   assign rx_live = cfg_reg[`EMRX_BIT_RXEN] & ~whole_hold & ~cfg_reg[`EMRX_BIT_RXFN]; // see (R16)
   assign fcs_inc = rx_live & rx_frame_end & rx_fcs_fail & ~rx_odd_bits; // see (R1)
   assign algn_inc = rx_live & rx_frame_end & rx_fcs_fail & rx_odd_bits; // see (R2)
   assign int_events = {algn_inc, fcs_inc};

   // ****************************************************
   // wishbone decode
   // ****************************************************
   assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr = req & wb_we_i;
   assign rd = req & ~wb_we_i;
   assign low_lanes = wb_sel_i[0] | wb_sel_i[1];
   assign wdat = wb_dat_i[CNT_W-1:0];

   always @*
   begin
      cfg_next = cfg_reg;
      int_en_next = int_en_reg;
      int_clr = {`EMRX_INT_W{1'b0}};
      fcs_load = 1'b0;
      algn_load = 1'b0;
      fcs_rd_clear = 1'b0;
      algn_rd_clear = 1'b0;
      fcs_load_data = fcs_count;
      algn_load_data = algn_count;
      dat_next = 32'h00000000;
      if (wb_adr_i == `EMRX_OFS_CFG1)
      begin
         if (wr)
            cfg_next = lane_merge(cfg_reg, wdat, wb_sel_i[1:0]) & `EMRX_CFG_MASK; // see (R17)
         dat_next = {16'h0000, cfg_reg};
      end
      else if (wb_adr_i == `EMRX_OFS_FCS)
      begin
         fcs_load = wr;
         fcs_load_data = lane_merge(fcs_count, wdat, wb_sel_i[1:0]);
         fcs_rd_clear = rd & low_lanes; // see (R4)
         dat_next = {16'h0000, fcs_count}; // see (R3)
      end
      else if (wb_adr_i == `EMRX_OFS_FCS_SET)
      begin
         fcs_load = wr; // see (R5)
         fcs_load_data = lane_merge(fcs_count, fcs_count | wdat, wb_sel_i[1:0]);
      end
      else if (wb_adr_i == `EMRX_OFS_FCS_CLR)
      begin
         fcs_load = wr;
         fcs_load_data = lane_merge(fcs_count, fcs_count & ~wdat, wb_sel_i[1:0]);
      end
      else if (wb_adr_i == `EMRX_OFS_FCS_INV)
      begin
         fcs_load = wr;
         fcs_load_data = lane_merge(fcs_count, fcs_count ^ wdat, wb_sel_i[1:0]);
      end
      else if (wb_adr_i == `EMRX_OFS_ALGN)
      begin
         algn_load = wr;
         algn_load_data = lane_merge(algn_count, wdat, wb_sel_i[1:0]);
         algn_rd_clear = rd & low_lanes; // see (R4)
         dat_next = {16'h0000, algn_count}; // see (R3)
      end
      else if (wb_adr_i == `EMRX_OFS_ALGN_SET)
      begin
         algn_load = wr; // see (R5)
         algn_load_data = lane_merge(algn_count, algn_count | wdat, wb_sel_i[1:0]);
      end
      else if (wb_adr_i == `EMRX_OFS_ALGN_CLR)
      begin
         algn_load = wr;
         algn_load_data = lane_merge(algn_count, algn_count & ~wdat, wb_sel_i[1:0]);
      end
      else if (wb_adr_i == `EMRX_OFS_ALGN_INV)
      begin
         algn_load = wr;
         algn_load_data = lane_merge(algn_count, algn_count ^ wdat, wb_sel_i[1:0]);
      end
      else if (wb_adr_i == `EMRX_OFS_INT_STAT)
      begin
         dat_next = {{(32-`EMRX_INT_W){1'b0}}, int_stat_reg};
      end
      else if (wb_adr_i == `EMRX_OFS_INT_CLR)
      begin
         if (wr & wb_sel_i[0])
            int_clr = wb_dat_i[`EMRX_INT_W-1:0];
      end
      else if (wb_adr_i == `EMRX_OFS_INT_EN)
      begin
         if (wr & wb_sel_i[0])
            int_en_next = wb_dat_i[`EMRX_INT_W-1:0];
         dat_next = {{(32-`EMRX_INT_W){1'b0}}, int_en_reg};
      end
      // a new event beats a clear written in the same cycle
      int_stat_next = (int_stat_reg & ~int_clr) | int_events;
   end

   // ****************************************************
   // error tallies
   // ****************************************************
   emrx_err_counter #(
      .W(CNT_W)
   ) u_fcs_tally (
      .mclk(mclk),
      .reset(reset),
      .inc(fcs_inc),
      .rd_clear(fcs_rd_clear),
      .load(fcs_load),
      .load_data(fcs_load_data),
      .count(fcs_count)
   );

   emrx_err_counter #(
      .W(CNT_W)
   ) u_algn_tally (
      .mclk(mclk),
      .reset(reset),
      .inc(algn_inc),
      .rd_clear(algn_rd_clear),
      .load(algn_load),
      .load_data(algn_load_data),
      .count(algn_count)
   );

   // ****************************************************
   // registers and bus answer
   // ****************************************************
   always @(posedge mclk)
   begin
      if (reset)
      begin
         cfg_reg <= `EMRX_CFG_RESET; // see (R6)
         int_stat_reg <= {`EMRX_INT_W{1'b0}};
         int_en_reg <= {`EMRX_INT_W{1'b0}};
         irq_reg <= 1'b0;
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end
      else
      begin
         cfg_reg <= cfg_next;
         int_stat_reg <= int_stat_next;
         int_en_reg <= int_en_next;
         irq_reg <= |(int_stat_next & int_en_next);
         ack_reg <= req;
         dat_reg <= req ? dat_next : 32'h00000000;
      end
   end

   // ****************************************************
   // mac side controls
   // ****************************************************
   // sub-block holds also follow the whole mac hold
   always @(posedge mclk)
   begin
      if (reset)
      begin
         hold_reg <= 6'h3F;
         mii_txd_reg <= {MII_W{1'b0}};
         mii_tx_en_reg <= 1'b0;
         mac_rx_data_reg <= {MII_W{1'b0}};
         mac_rx_dv_reg <= 1'b0;
         frame_accept_reg <= 1'b0;
         pause_apply_reg <= 1'b0;
         tx_pause_go_reg <= 1'b0;
      end
      else
      begin
         hold_reg[5] <= whole_hold; // see (R6)
         hold_reg[4] <= cfg_reg[`EMRX_BIT_BACKOFF] | whole_hold; // see (R7)
         hold_reg[3] <= cfg_reg[`EMRX_BIT_RXCS] | whole_hold; // see (R8)
         hold_reg[2] <= cfg_reg[`EMRX_BIT_RXFN] | whole_hold; // see (R9)
         hold_reg[1] <= cfg_reg[`EMRX_BIT_TXCS] | whole_hold; // see (R10)
         hold_reg[0] <= cfg_reg[`EMRX_BIT_TXFN] | whole_hold; // see (R11)
         // in loopback the phy sees no transmit, trading line activity for a clean test
         if (cfg_reg[`EMRX_BIT_LOOP]) // see (R12)
         begin
            mii_txd_reg <= {MII_W{1'b0}};
            mii_tx_en_reg <= 1'b0;
            mac_rx_data_reg <= tx_data;
            mac_rx_dv_reg <= tx_en & rx_live;
         end
         else
         begin
            mii_txd_reg <= tx_data;
            mii_tx_en_reg <= tx_en & ~whole_hold & ~cfg_reg[`EMRX_BIT_TXFN]; // see (R11)
            mac_rx_data_reg <= phy_rxd_s;
            mac_rx_dv_reg <= phy_rx_dv_s & rx_live; // see (R16)
         end
         frame_accept_reg <= rx_live & rx_frame_end & ~rx_fcs_fail &
            (~rx_control_frame | cfg_reg[`EMRX_BIT_PASS]); // see (R15)
         pause_apply_reg <= rx_live & rx_frame_end & ~rx_fcs_fail & rx_pause_frame &
            cfg_reg[`EMRX_BIT_RXFLOW] & ~cfg_reg[`EMRX_BIT_RXCS]; // see (R14)
         tx_pause_go_reg <= tx_pause_req & cfg_reg[`EMRX_BIT_TXFLOW] & ~whole_hold &
            ~cfg_reg[`EMRX_BIT_TXCS]; // see (R13)
      end
   end

   // ****************************************************
   // outputs
   // ****************************************************
   assign wb_dat_o = dat_reg;
   assign wb_ack_o = ack_reg;
   assign irq = irq_reg;
   assign mii_txd = mii_txd_reg;
   assign mii_tx_en = mii_tx_en_reg;
   assign mac_rx_data = mac_rx_data_reg;
   assign mac_rx_dv = mac_rx_dv_reg;
   assign frame_accept = frame_accept_reg;
   assign pause_apply = pause_apply_reg;
   assign tx_pause_go = tx_pause_go_reg;
   assign mac_and_media_logic_hold = hold_reg[5];
   assign backoff_random_hold = hold_reg[4];
   assign rx_control_sublayer_hold = hold_reg[3];
   assign rx_function_hold = hold_reg[2];
   assign tx_control_sublayer_hold = hold_reg[1];
   assign tx_function_hold = hold_reg[0];
endmodule

// ---- emrx_top_tb_top.sv ----
// scenario bench for the rx error tallies, configuration one and interrupt
// assumes emrx_top, its checker and the phy model are compiled first
`timescale 1ns/1ps
`include "emrx_consts.vh"
module emrx_top_tb_top;
   // ****************************************************
   // signals
   // ****************************************************
   logic mclk = 0, reset = 1, cyc = 0, stb = 0, we = 0, fe = 0, fcs = 0, odd = 0;
   logic ctl = 0, pse = 0, treq = 0, ten = 0, go = 0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0, tdat = 4'h0, gnib = 4'h0;
   logic [31:0] wdat = 32'h0;
   wire logic [31:0] rdat;
   wire logic [3:0] prxd, mtxd, mrxd;
   wire logic [5:0] h;
   wire logic ack, irq, pdv, mten, mrdv, acc, papp, pgo;
   int err_total = 0, check_count = 0;
   always #4 mclk = ~mclk;
   emrx_phy_model u_phy (.mclk(mclk), .go(go), .nib(gnib), .rxd(prxd), .rx_dv(pdv));
   emrx_top DUT (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .irq(irq), .rx_frame_end(fe), .rx_fcs_fail(fcs),
      .rx_odd_bits(odd), .rx_control_frame(ctl), .rx_pause_frame(pse),
      .tx_pause_req(treq), .tx_data(tdat), .tx_en(ten), .phy_rxd(prxd),
      .phy_rx_dv(pdv), .mii_txd(mtxd), .mii_tx_en(mten), .mac_rx_data(mrxd),
      .mac_rx_dv(mrdv), .frame_accept(acc), .pause_apply(papp), .tx_pause_go(pgo),
      .mac_and_media_logic_hold(h[5]), .backoff_random_hold(h[4]),
      .rx_control_sublayer_hold(h[3]), .rx_function_hold(h[2]),
      .tx_control_sublayer_hold(h[1]), .tx_function_hold(h[0]));
   // ****************************************************
   // shared tasks
   // ****************************************************
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // classic cycle: starts just after an edge, ends one idle edge after ack
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      // no cycle limit here: only the watchdog ends a wait for ack
      do
      begin
         @(posedge mclk);
      end
      while (ack !== 1'h1);
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
      @(posedge mclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'h1, a, d, 4'hF, q);
   endtask
   task rd(input logic [7:0] a, input logic [3:0] s, input logic [31:0] e);
      logic [31:0] q;
      wb(1'h0, a, 32'h0, s, q);
      chk(q, e);
   endtask
   // k is fcs fail, odd length, control, pause; e is accept, pause applied
   task frm(input logic [3:0] k, input logic [1:0] e);
      fe <= 1'h1;
      {fcs, odd, ctl, pse} <= k;
      @(posedge mclk);
      fe <= 1'h0;
      #1;
      chk({acc, papp}, e);
      @(posedge mclk);
   endtask
   task tpz(input logic e);
      treq <= 1'h1;
      @(posedge mclk);
      treq <= 1'h0;
      #1;
      chk(pgo, e);
      @(posedge mclk);
   endtask
   // ****************************************************
   // scenarios
   // ****************************************************
   task t_cfg;
      chk(h, 6'h3F);
      rd(8'h00, 4'hF, 32'h800D);
      rd(8'h10, 4'hF, 32'h0);
      rd(8'h40, 4'hF, 32'h0);
      wr(8'h00, 32'hFFFFFFFF);
      rd(8'h00, 4'hF, 32'h0000CF1F);
      for (int i = 0; i < 5; i++)
      begin
         wr(8'h00, 32'h1 << ((i == 0) ? 14 : 12 - i));
         chk(h, 6'h10 >> i);
      end
      wr(8'h00, 32'h0D);
      chk(h, 6'h00);
   endtask
   task t_counts;
      frm(4'h8, 2'h0);
      frm(4'h8, 2'h0);
      frm(4'hC, 2'h0);
      frm(4'h0, 2'h2);
      rd(8'h10, 4'hC, 32'h2);
      rd(8'h10, 4'h1, 32'h2);
      rd(8'h10, 4'h2, 32'h0);
      rd(8'h20, 4'hF, 32'h1);
      rd(8'h20, 4'hF, 32'h0);
      wr(8'h10, 32'hFFFFFFFF);
      rd(8'h10, 4'hF, 32'hFFFF);
      wr(8'h10, 32'hFFFF);
      frm(4'h8, 2'h0);
      rd(8'h10, 4'hF, 32'h0);
      wr(8'h24, 32'hFFFF);
      frm(4'hC, 2'h0);
      rd(8'h20, 4'hF, 32'h0);
      // software edits the fcs tally by a direct write, then through the set, clear and invert aliases, and the alignment tally through invert then clear
      wr(8'h10, 32'h00F0);
      wr(8'h14, 32'h0F00);
      wr(8'h18, 32'h0030);
      wr(8'h1C, 32'h00FF);
      rd(8'h1C, 4'hF, 32'h0);
      rd(8'h10, 4'hF, 32'h0F3F);
      wr(8'h2C, 32'h1234);
      wr(8'h28, 32'h0204);
      rd(8'h20, 4'hF, 32'h1030);
   endtask
   task t_flow;
      frm(4'h2, 2'h0);
      frm(4'h3, 2'h1);
      wr(8'h00, 32'h0B);
      frm(4'h3, 2'h2);
      tpz(1'h1);
      wr(8'h00, 32'h02);
      frm(4'h0, 2'h0);
      frm(4'h8, 2'h0);
      rd(8'h10, 4'hF, 32'h0);
      tpz(1'h0);
   endtask
   task t_loop;
      ten <= 1'h1;
      tdat <= 4'hA;
      go <= 1'h1;
      gnib <= 4'h5;
      wr(8'h00, 32'h1D);
      chk({mrdv, mrxd, mten}, 32'h34);
      wr(8'h00, 32'h0D);
      chk({mrdv, mrxd, mten, mtxd}, 32'h2BA);
      go <= 1'h0;
      ten <= 1'h0;
   endtask
   task t_irq;
      // earlier scenarios left both status bits set
      wr(8'h34, 32'h3);
      rd(8'h30, 4'hF, 32'h0);
      wr(8'h38, 32'h3);
      chk(irq, 1'h0);
      frm(4'h8, 2'h0);
      chk(irq, 1'h1);
      rd(8'h30, 4'hF, 32'h1);
      wr(8'h34, 32'h1);
      chk(irq, 1'h0);
      wr(8'h38, 32'h0);
      frm(4'hC, 2'h0);
      chk(irq, 1'h0);
      rd(8'h30, 4'hF, 32'h2);
      wr(8'h38, 32'h2);
      chk(irq, 1'h1);
      wr(8'h34, 32'h2);
      chk(irq, 1'h0);
   endtask
   // a reset in mid-run must bring back the reset values of the hold outputs, configuration one and the fcs tally
   task t_reset;
      wr(8'h00, 32'h0);
      wr(8'h10, 32'h5);
      reset <= 1'h1;
      repeat (2) @(posedge mclk);
      reset <= 1'h0;
      @(posedge mclk);
      chk(h, 6'h3F);
      rd(8'h00, 4'hF, 32'h800D);
      rd(8'h10, 4'hF, 32'h0);
   endtask
   initial
   begin
      repeat (8) @(posedge mclk);
      reset <= 1'h0;
      @(posedge mclk);
      t_cfg;
      t_counts;
      t_flow;
      t_loop;
      t_irq;
      t_reset;
      report_and_stop;
   end
   // the whole run needs well under two thousand cycles
   initial
   begin
      #100000;
      err_total++;
      report_and_stop;
   end
endmodule
